// File: src/pspc_map.vh
// Purpose: register map and field constants of the parallel slave port block
// Assumes: 8-bit register bus, byte offsets as printed
// Notes:   included by pspc_top.v
`ifndef PSPC_MAP_VH
`define PSPC_MAP_VH

// register offsets
`define PSPC_ADDR_DATA      8'h08
`define PSPC_ADDR_CTRL_PORT 8'h09
`define PSPC_ADDR_DIR_D     8'h88
`define PSPC_ADDR_DIR_STAT  8'h89

// ctrl_dir_status_reg fields
`define PSPC_BIT_IBF        7
`define PSPC_BIT_OBF        6
`define PSPC_BIT_IN_BUF_OVERFLOW       5
`define PSPC_BIT_MODE       4

// control pin positions
`define PSPC_PIN_RD         0
`define PSPC_PIN_WR         1
`define PSPC_PIN_CS         2

// reset values
`define PSPC_RST_DIR_D      8'hff
`define PSPC_RST_DIR_E      3'h7
`define PSPC_RST_DATA       8'h00
`define PSPC_RST_CTRL_PORT  3'h0

// core cycles from detected end of strobe to done pulse, flag set one later
`define PSPC_DONE_DLY       2

`endif

// File: src/pspc_sync.v
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: single core clock
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none

module pspc_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] rst_val_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_reg <= rst_val_i;
            sync_reg <= rst_val_i;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule // pspc_sync

`default_nettype wire

// File: src/pspc_top.v
// Purpose: data port and control port with parallel slave port mode
// Assumes: host strobes asynchronous, register bus synchronous to clk_sys_i
// Notes:   analog selection of control pins comes from outside
//
// Contract
// - data pins are general I/O or slave port data bus bits in slave mode
// - data direction register at 88h resets to all ones (inputs)
// - data latch at 08h undefined at power-on, kept over other resets
// - three control pins, each direction set independently
// - slave mode makes control pins read, write and chip-select inputs
// - control pin configured analog reads as zero
// - control direction bits still drive output enables while analog
// - after power-on control pins are analog and read zero
// - status register at 89h resets to 0000 -111, bit 3 reads zero
// - bits 2..0 set chip-select, write, read pin direction; one is input
// - low read with chip select drives output latch on data pins
// - low write with chip select captures data pins into input latch
// - chip select low selects; high makes strobes ineffective
// - end of write sets input-full and irq flag after fixed delay
// - input-full cleared only by processor read of input latch; code also clears it while the mode bit is zero
// - output-full clears on read detect, stays clear until processor write
// - overflow set by second host write before read, cleared by software
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pspc_map.vh"

module pspc_top #(
    parameter DONE_DLY = `PSPC_DONE_DLY
) (
    input  wire       clk_sys_i,
    input  wire       rst_i,
    input  wire       por_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output wire [7:0] rdata_o,
    input  wire [2:0] analog_sel_i,
    input  wire [7:0] data_pin_i,
    output wire [7:0] data_pin_o,
    output wire [7:0] data_pin_oe_o,
    input  wire [2:0] ctrl_pin_i,
    output wire [2:0] ctrl_pin_o,
    output wire [2:0] ctrl_pin_oe_o,
    output wire       slave_port_irq_flag_o
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function dec;
        input [7:0] a;
        input [7:0] off;
        begin
            dec = (a == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers

    wire [7:0] data_sync;
    wire [2:0] ctrl_sync;

    pspc_sync #(
        .WIDTH (8)
    ) u_sync_data (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .rst_val_i (8'h00),
        .async_i   (data_pin_i),
        .sync_o    (data_sync)
    );

    pspc_sync #(
        .WIDTH (3)
    ) u_sync_ctrl (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .rst_val_i (3'h7),
        .async_i   (ctrl_pin_i),
        .sync_o    (ctrl_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    reg [7:0]          out_latch_reg;
    reg [7:0]          in_latch_reg;
    reg [2:0]          ctrl_latch_reg;
    reg [7:0]          dir_d_reg;
    reg [2:0]          dir_e_reg;
    reg                mode_reg;
    reg                ibf_reg;
    reg                obf_reg;
    reg                in_buf_overflow_reg;
    reg                wr_act_reg;
    reg                rd_act_reg;
    reg [DONE_DLY-1:0] wr_done_sh_reg;
    reg [DONE_DLY-1:0] rd_done_sh_reg;
    reg [7:0]          rdata_reg;
    reg [7:0]          data_o_reg;
    reg [7:0]          data_oe_reg;
    reg [2:0]          ctrl_o_reg;
    reg [2:0]          ctrl_oe_reg;
    reg                irq_reg;

    wire sel_data = dec(addr_i, `PSPC_ADDR_DATA);
    wire sel_port = dec(addr_i, `PSPC_ADDR_CTRL_PORT);
    wire sel_dird = dec(addr_i, `PSPC_ADDR_DIR_D);
    wire sel_stat = dec(addr_i, `PSPC_ADDR_DIR_STAT);

    ////////////////////////////////////////////////////////////////////////////
    // host strobe detection

    wire cs_n    = ctrl_sync[`PSPC_PIN_CS];
    wire wr_n    = ctrl_sync[`PSPC_PIN_WR];
    wire rd_n    = ctrl_sync[`PSPC_PIN_RD];
    wire wr_act  = mode_reg & ~cs_n & ~wr_n;
    wire rd_act  = mode_reg & ~cs_n & ~rd_n;
    wire wr_rise = wr_act & ~wr_act_reg;
    wire wr_end  = ~wr_act & wr_act_reg;
    wire rd_rise = rd_act & ~rd_act_reg;
    wire rd_end  = ~rd_act & rd_act_reg;
    wire wr_done = wr_done_sh_reg[DONE_DLY-1];
    wire rd_done = rd_done_sh_reg[DONE_DLY-1];

    wire cpu_wr_data = wr_i & sel_data;
    wire cpu_rd_data = rd_i & sel_data;
    wire cpu_wr_stat = wr_i & sel_stat;

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    wire [7:0] stat_val = {ibf_reg, obf_reg, in_buf_overflow_reg, mode_reg, 1'b0, dir_e_reg};
    wire [2:0] port_val;

    genvar gi;

    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_port_val
            assign port_val[gi] = analog_sel_i[gi] ? 1'b0 : ctrl_sync[gi];
        end
    endgenerate

    reg [7:0] rdata_next;

    always @* begin
        rdata_next = 8'h00;
        if (rd_i) begin
            if (sel_data) begin
                rdata_next = mode_reg ? in_latch_reg : data_sync;
            end else if (sel_port) begin
                rdata_next = {5'h00, port_val};
            end else if (sel_dird) begin
                rdata_next = dir_d_reg;
            end else if (sel_stat) begin
                rdata_next = stat_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data and control latches

    always @(posedge clk_sys_i) begin
        if (rst_i && por_i) begin
            out_latch_reg  <= `PSPC_RST_DATA;
            in_latch_reg   <= `PSPC_RST_DATA;
            ctrl_latch_reg <= `PSPC_RST_CTRL_PORT;
        end else begin
            if (cpu_wr_data) begin
                out_latch_reg <= wdata_i;
            end
            if (wr_act) begin
                in_latch_reg <= data_sync;
            end
            if (wr_i && sel_port) begin
                ctrl_latch_reg <= wdata_i[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            dir_d_reg <= `PSPC_RST_DIR_D;
            dir_e_reg <= `PSPC_RST_DIR_E;
            mode_reg  <= 1'b0;
        end else begin
            if (wr_i && sel_dird) begin
                dir_d_reg <= wdata_i;
            end
            if (cpu_wr_stat) begin
                dir_e_reg <= wdata_i[2:0];
                mode_reg  <= wdata_i[`PSPC_BIT_MODE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags, set wins over clear except the clear while the mode bit is zero

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            ibf_reg  <= 1'b0;
            obf_reg  <= 1'b0;
            in_buf_overflow_reg <= 1'b0;
        end else begin
            if (!mode_reg) begin
                ibf_reg <= 1'b0;
            end else if (wr_done) begin
                ibf_reg <= 1'b1;
            end else if (cpu_rd_data) begin
                ibf_reg <= 1'b0;
            end
            if (!mode_reg) begin
                obf_reg <= 1'b0;
            end else if (cpu_wr_data) begin
                obf_reg <= 1'b1;
            end else if (rd_rise) begin
                obf_reg <= 1'b0;
            end
            if (wr_rise && ibf_reg) begin
                in_buf_overflow_reg <= 1'b1;
            end else if (cpu_wr_stat) begin
                in_buf_overflow_reg <= wdata_i[`PSPC_BIT_IN_BUF_OVERFLOW];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strobe history and completion delay

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_act_reg     <= 1'b0;
            rd_act_reg     <= 1'b0;
            wr_done_sh_reg <= {DONE_DLY{1'b0}};
            rd_done_sh_reg <= {DONE_DLY{1'b0}};
        end else begin
            wr_act_reg     <= wr_act;
            rd_act_reg     <= rd_act;
            wr_done_sh_reg <= {wr_done_sh_reg[DONE_DLY-2:0], wr_end};
            rd_done_sh_reg <= {rd_done_sh_reg[DONE_DLY-2:0], rd_end};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data register

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers

    wire [7:0] data_oe_next;

    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_data_oe
            assign data_oe_next[gi] = mode_reg ? rd_act : ~dir_d_reg[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            data_o_reg  <= 8'h00;
            data_oe_reg <= 8'h00;
            ctrl_o_reg  <= 3'h0;
            ctrl_oe_reg <= 3'h0;
            irq_reg     <= 1'b0;
        end else begin
            data_o_reg  <= out_latch_reg;
            data_oe_reg <= data_oe_next;
            ctrl_o_reg  <= ctrl_latch_reg;
            ctrl_oe_reg <= ~dir_e_reg;
            irq_reg     <= wr_done | rd_done;
        end
    end

    assign rdata_o               = rdata_reg;
    assign data_pin_o            = data_o_reg;
    assign data_pin_oe_o         = data_oe_reg;
    assign ctrl_pin_o            = ctrl_o_reg;
    assign ctrl_pin_oe_o         = ctrl_oe_reg;
    assign slave_port_irq_flag_o = irq_reg;

endmodule // pspc_top

`default_nettype wire

// File: verif/pspc_assertions.sv
// Purpose: port checks of the slave port block
// Assumes: one clock, sync reset
// Notes:   mode_reg follows the select bit
`timescale 1ns/1ps
`default_nettype none
module pspc_chk (
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [2:0] analog_sel_i,
    input wire logic [2:0] ctrl_pin_i,
    input wire logic [7:0] data_pin_o,
    input wire logic [7:0] data_pin_oe_o,
    input wire logic [2:0] ctrl_pin_oe_o,
    input wire logic       slave_port_irq_flag_o
);
    logic mode_reg;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_sys_i)
        if (rst_i)
            mode_reg <= 1'b0;
        else if (wr_i && addr_i == 8'h89)
            mode_reg <= wdata_i[4];
    dir_reset_a: assert property (disable iff (1'b0)
        rst_i |=> data_pin_oe_o == 8'h00 && ctrl_pin_oe_o == 3'h0) else $error("oe reset");
    dir_write_a: assert property (wr_i && addr_i == 8'h88 && !mode_reg
        |-> ##2 data_pin_oe_o == ~$past(wdata_i, 2)) else $error("data dir");
    ctrl_dir_a: assert property (wr_i && addr_i == 8'h89
        |-> ##2 {5'h00, ctrl_pin_oe_o} == (~$past(wdata_i, 2) & 8'h07)) else $error("ctrl dir");
    latch_out_a: assert property (wr_i && addr_i == 8'h08
        |-> ##2 data_pin_o == $past(wdata_i, 2)) else $error("out latch");
    mode_read_a: assert property (rd_i && addr_i == 8'h89
        |=> rdata_o[4:3] == {$past(mode_reg), 1'b0}) else $error("status read");
    analog_zero_a: assert property (rd_i && addr_i == 8'h09
        |=> (rdata_o & {5'h1f, $past(analog_sel_i)}) == 8'h00) else $error("analog read");
    read_drive_a: assert property ((mode_reg && !ctrl_pin_i[0] && !ctrl_pin_i[2]) [*5]
        |-> data_pin_oe_o == 8'hff) else $error("read drive");
    idle_release_a: assert property ((mode_reg && (ctrl_pin_i[0] || ctrl_pin_i[2])) [*5]
        |-> data_pin_oe_o == 8'h00) else $error("idle drive");
    irq_pulse_a: assert property (slave_port_irq_flag_o |=> !slave_port_irq_flag_o)
        else $error("irq width");
endmodule // pspc_chk
bind pspc_top pspc_chk u_chk (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .analog_sel_i, .ctrl_pin_i, .data_pin_o, .data_pin_oe_o, .ctrl_pin_oe_o,
    .slave_port_irq_flag_o);
`default_nettype wire

// File: verif/pspc_host.sv
// Purpose: host processor on the slave port pins
// Assumes: strobes low active
// Notes:   released data lines follow a shifting pattern, one line toggles each cycle
`timescale 1ns/1ps
`default_nettype none
module pspc_host (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] data_pin_o,
    input  wire logic [7:0] data_pin_oe_o,
    input  wire logic [2:0] ctrl_pin_o,
    input  wire logic [2:0] ctrl_pin_oe_o,
    output var  logic [7:0] data_pin_i,
    output var  logic [2:0] ctrl_pin_i
);
    logic [7:0] drv_data  = 8'h00;
    logic       drv_en    = 1'b0;
    logic [2:0] strobe_n  = 3'h7;
    logic [7:0] noise_reg = 8'h00;
    always @(posedge clk_sys_i)
        noise_reg <= {noise_reg[6:0], ~noise_reg[7]};
    always_comb begin
        data_pin_i = (data_pin_oe_o & data_pin_o)
                   | (~data_pin_oe_o & (drv_en ? drv_data : noise_reg));
        ctrl_pin_i = (ctrl_pin_oe_o & ctrl_pin_o) | (~ctrl_pin_oe_o & strobe_n);
    end
    task automatic write_byte(input logic [7:0] d, input logic sel_n);
        @(posedge clk_sys_i);
        drv_data <= d;
        drv_en   <= 1'b1;
        strobe_n <= {sel_n, 2'b01};
        repeat (4) @(posedge clk_sys_i);
        strobe_n <= 3'h7;
        repeat (3) @(posedge clk_sys_i);
        drv_en   <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic read_byte(output logic [7:0] d);
        @(posedge clk_sys_i);
        strobe_n <= 3'h2;
        repeat (6) @(posedge clk_sys_i);
        #1;
        d = data_pin_i;
        @(posedge clk_sys_i);
        strobe_n <= 3'h7;
        repeat (8) @(posedge clk_sys_i);
    endtask
endmodule // pspc_host
`default_nettype wire

// File: verif/tb.sv
// Purpose: bench of the slave port block
// Assumes: host model on the pins
// Notes:   register tests then host transfers
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk_sys_i    = 1'b0;
    logic       rst_i        = 1'b1;
    logic       por_i        = 1'b1;
    logic [7:0] addr_i       = 8'h00;
    logic [7:0] wdata_i      = 8'h00;
    logic       wr_i         = 1'b0;
    logic       rd_i         = 1'b0;
    logic [2:0] analog_sel_i = 3'h7;
    logic [7:0] rdata_o, data_pin_i, data_pin_o, data_pin_oe_o, v;
    logic [2:0] ctrl_pin_i, ctrl_pin_o, ctrl_pin_oe_o;
    logic       slave_port_irq_flag_o;
    logic [7:0] n_irq    = 8'h00;
    int         n_errors = 0;
    int         n_tests  = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
        if (slave_port_irq_flag_o === 1'b1)
            n_irq <= n_irq + 8'h01;
    pspc_top dut (.clk_sys_i, .rst_i, .por_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .analog_sel_i, .data_pin_i, .data_pin_o, .data_pin_oe_o, .ctrl_pin_i, .ctrl_pin_o,
        .ctrl_pin_oe_o, .slave_port_irq_flag_o);
    pspc_host host (.clk_sys_i, .data_pin_o, .data_pin_oe_o, .ctrl_pin_o, .ctrl_pin_oe_o,
        .data_pin_i, .ctrl_pin_i);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    task automatic pause;
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic print_verdict;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk(data_pin_oe_o, 8'h00);
        chk({5'h00, ctrl_pin_oe_o}, 8'h00);
        chk(data_pin_o, 8'h00);
        rchk(8'h88, 8'hff);
        rchk(8'h89, 8'h07);
        rchk(8'h09, 8'h00);
        $display("test reset done");
        wr(8'h88, 8'h0f);
        wr(8'h08, 8'h5a);
        pause;
        chk(data_pin_oe_o, 8'hf0);
        chk(data_pin_o, 8'h5a);
        rchk(8'h40, 8'h00);
        @(posedge clk_sys_i);
        analog_sel_i <= 3'h2;
        wr(8'h89, 8'h02);
        wr(8'h09, 8'h05);
        pause;
        chk({5'h00, ctrl_pin_oe_o}, 8'h05);
        chk({5'h00, ctrl_pin_o}, 8'h05);
        rchk(8'h09, 8'h05);
        @(posedge clk_sys_i);
        analog_sel_i <= 3'h0;
        pause;
        rchk(8'h09, 8'h07);
        $display("test io done");
        wr(8'h89, 8'h07);
        pause;
        wr(8'h89, 8'hd7);
        rchk(8'h89, 8'h17);
        wr(8'h08, 8'ha5);
        rchk(8'h89, 8'h57);
        host.read_byte(v);
        chk(v, 8'ha5);
        rchk(8'h89, 8'h17);
        chk(n_irq, 8'h01);
        host.write_byte(8'h3c, 1'b0);
        rchk(8'h89, 8'h97);
        chk(n_irq, 8'h02);
        host.write_byte(8'hc3, 1'b0);
        rchk(8'h89, 8'hb7);
        rchk(8'h08, 8'hc3);
        rchk(8'h89, 8'h37);
        wr(8'h89, 8'h17);
        rchk(8'h89, 8'h17);
        host.write_byte(8'h55, 1'b1);
        rchk(8'h89, 8'h17);
        chk(n_irq, 8'h03);
        $display("test slave done");
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        pause;
        chk(data_pin_o, 8'ha5);
        rchk(8'h89, 8'h07);
        $display("test warm reset done");
        print_verdict;
    end
endmodule // tb
`default_nettype wire
